// File: logic/gpw_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpw_cfg.svh"

// Summary of operation
// - Register 0x11 holds sources, values and directions of pins 13 and 14.
// - Direction 1 drives the pin; value bits read back the live pin level.
// - Pin 13 source: 0 register bit, 2 AND of pins 4,5, 3 OR.
// - Pin 13 source 1: flip-flop clocked by pin 10, data pin 9, reset-cleared.
// - Pin 14 source: 0 register bit, 2 NAND of pins 8,9, 3 NOR.
// - Pin 14 source 1: flip-flop clocked by external clock, data pin 8.
// - Side port level write sets outputs; read returns all eight live lines.
// - Side lines 1 and 0 may carry peripheral address lines 5 and 4.
// - Side direction bit 1 makes the line output; all inputs after reset.
// - Polarity bits invert side lines only on the wake path.
// - Wake-enable bits let their line raise the wake event.
// - Divider A divides its source by twice ratio plus two.
// - Divider B divides its source by twice its ratio plus two.
// - Divider A source: 12 MHz, external clock, pin 10, pin 0.
// - Divider B source: 93.75 kHz, external clock, pin 1, divider A.
// - Each divider has input invert and hold bits in the control register.
// - Pin 8: dir bit 0, value bit 1, source register, A, B, NAND 0,1.
// - Pin 9 as pin 8, source 3 is NAND of pins 2 and 3.
// - Pin 10 as pin 8, source 3 passes the external clock.
module gpw_top #(
   parameter int RATIO_W = 8
) (
   // clock and reset
   input  wire logic               CLK_SYS_I,
   input  wire logic               SRST_I,
   // register access
   input  wire gpw_pkg::gpw_req_type REG_REQ_I,
   output var  logic [7:0]         REG_RDATA_O,
   // pins 0 to 7, levels only
   input  wire logic [7:0]         GP_LOW_I,
   // pins 8, 9, 10, 13, 14
   input  wire gpw_pkg::gpw_pins_type PIN_I,
   output var  logic [4:0]         PIN_O,
   output var  logic [4:0]         PIN_OE_O,
   input  wire logic               EXT_CLK_I,
   // side port
   input  wire logic [7:0]         AUX_I,
   output var  logic [7:0]         AUX_O,
   output var  logic [7:0]         AUX_OE_O,
   input  wire logic               AUX_ADDR_MODE_I,
   input  wire logic [1:0]         PERIPH_ADDR_HI_I,
   // wake request
   output var  logic               WAKE_O
);

   if (RATIO_W != 8) begin : g_chk
      $error("gpw_top: RATIO_W must be 8");
   end

   // ==================================================================
   // internal reference clocks, fractional toggle generators
   localparam logic [`GPW_ACC_W-1:0] SYS_V = `GPW_ACC_W'(`GPW_SYS_HZ);
   localparam logic [`GPW_ACC_W-1:0] INC_V [2] = '{`GPW_ACC_W'(2 * `GPW_FAST_HZ),
                                                   `GPW_ACC_W'(2 * `GPW_SLOW_HZ)};
   logic [`GPW_ACC_W-1:0] acc_reg  [2];
   logic [`GPW_ACC_W-1:0] acc_next [2];
   logic [1:0]            ref_reg;
   logic [1:0]            ref_next;

   for (genvar g = 0; g < 2; g++) begin : g_ref
      always_comb begin
         if (acc_reg[g] + INC_V[g] >= SYS_V) begin
            acc_next[g] = acc_reg[g] + INC_V[g] - SYS_V;
            ref_next[g] = ~ref_reg[g];
         end else begin
            acc_next[g] = acc_reg[g] + INC_V[g];
            ref_next[g] = ref_reg[g];
         end
      end
      always_ff @(posedge CLK_SYS_I) begin
         if (SRST_I) begin
            acc_reg[g] <= '0;
            ref_reg[g] <= 1'b0;
         end else begin
            acc_reg[g] <= acc_next[g];
            ref_reg[g] <= ref_next[g];
         end
      end
   end

   // ==================================================================
   // register state
   logic [7:0] pin1314_reg, pin1314_next;
   logic [7:0] aux_lvl_reg, aux_lvl_next;
   logic [7:0] aux_dir_reg, aux_dir_next;
   logic [7:0] aux_pol_reg, aux_pol_next;
   logic [7:0] aux_wake_reg, aux_wake_next;
   logic [RATIO_W-1:0] ratio_reg [2];
   logic [RATIO_W-1:0] ratio_next [2];
   logic [7:0] divctl_reg, divctl_next;
   logic [3:0] pctl_reg [3];
   logic [3:0] pctl_next [3];
   logic [7:0] rdata_next;

   function automatic logic [7:0] rd_mux(input logic [7:0] a);
      unique case (a)
         `GPW_ADDR_PIN1314: rd_mux = {pin1314_reg[7:4], PIN_I.lvl[`GPW_PIN14],
                                      pin1314_reg[`GPW_P14_DIR], PIN_I.lvl[`GPW_PIN13],
                                      pin1314_reg[`GPW_P13_DIR]};
         `GPW_ADDR_AUXLVL:  rd_mux = AUX_I;
         `GPW_ADDR_AUXDIR:  rd_mux = aux_dir_reg;
         `GPW_ADDR_AUXPOL:  rd_mux = aux_pol_reg;
         `GPW_ADDR_AUXWAKE: rd_mux = aux_wake_reg;
         `GPW_ADDR_DIVA:    rd_mux = ratio_reg[0];
         `GPW_ADDR_DIVB:    rd_mux = ratio_reg[1];
         `GPW_ADDR_DIVCTL:  rd_mux = divctl_reg;
         `GPW_ADDR_PIN8:    rd_mux = {4'h0, pctl_reg[0]};
         `GPW_ADDR_PIN9:    rd_mux = {4'h0, pctl_reg[1]};
         `GPW_ADDR_PIN10:   rd_mux = {4'h0, pctl_reg[2]};
         default:           rd_mux = `GPW_READ_ZERO;
      endcase
   endfunction : rd_mux

   always_comb begin
      pin1314_next  = pin1314_reg;
      aux_lvl_next  = aux_lvl_reg;
      aux_dir_next  = aux_dir_reg;
      aux_pol_next  = aux_pol_reg;
      aux_wake_next = aux_wake_reg;
      ratio_next    = ratio_reg;
      divctl_next   = divctl_reg;
      pctl_next     = pctl_reg;
      rdata_next    = REG_RDATA_O;
      if (REG_REQ_I.wr) begin
         unique case (REG_REQ_I.addr)
            `GPW_ADDR_PIN1314: pin1314_next  = REG_REQ_I.wdata;
            `GPW_ADDR_AUXLVL:  aux_lvl_next  = REG_REQ_I.wdata;
            `GPW_ADDR_AUXDIR:  aux_dir_next  = REG_REQ_I.wdata;
            `GPW_ADDR_AUXPOL:  aux_pol_next  = REG_REQ_I.wdata;
            `GPW_ADDR_AUXWAKE: aux_wake_next = REG_REQ_I.wdata;
            `GPW_ADDR_DIVA:    ratio_next[0] = REG_REQ_I.wdata;
            `GPW_ADDR_DIVB:    ratio_next[1] = REG_REQ_I.wdata;
            `GPW_ADDR_DIVCTL:  divctl_next   = REG_REQ_I.wdata;
            `GPW_ADDR_PIN8:    pctl_next[0]  = REG_REQ_I.wdata[`GPW_PCTL_USED];
            `GPW_ADDR_PIN9:    pctl_next[1]  = REG_REQ_I.wdata[`GPW_PCTL_USED];
            `GPW_ADDR_PIN10:   pctl_next[2]  = REG_REQ_I.wdata[`GPW_PCTL_USED];
            default: ;
         endcase
      end
      if (REG_REQ_I.rd) begin
         rdata_next = rd_mux(REG_REQ_I.addr);
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         pin1314_reg  <= `GPW_RST_VAL;
         aux_lvl_reg  <= `GPW_RST_VAL;
         aux_dir_reg  <= `GPW_RST_VAL;
         aux_pol_reg  <= `GPW_RST_VAL;
         aux_wake_reg <= `GPW_RST_VAL;
         ratio_reg    <= '{`GPW_RST_VAL, `GPW_RST_VAL};
         divctl_reg   <= `GPW_RST_VAL;
         pctl_reg     <= '{4'h0, 4'h0, 4'h0};
         REG_RDATA_O  <= `GPW_RST_VAL;
      end else begin
         pin1314_reg  <= pin1314_next;
         aux_lvl_reg  <= aux_lvl_next;
         aux_dir_reg  <= aux_dir_next;
         aux_pol_reg  <= aux_pol_next;
         aux_wake_reg <= aux_wake_next;
         ratio_reg    <= ratio_next;
         divctl_reg   <= divctl_next;
         pctl_reg     <= pctl_next;
         REG_RDATA_O  <= rdata_next;
      end
   end

   // ==================================================================
   // clock dividers, edge-counted on the system clock
   logic [1:0]         dsrc;
   logic [1:0]         dprev_reg, dprev_next;
   logic [1:0]         dout_reg, dout_next;
   logic [1:0]         dedge;
   logic [1:0]         dhold;
   logic [RATIO_W-1:0] dcnt_reg [2];
   logic [RATIO_W-1:0] dcnt_next [2];

   always_comb begin
      unique case (divctl_reg[`GPW_DA_SRC])
         `GPW_SRC_0: dsrc[0] = ref_reg[0];
         `GPW_SRC_1: dsrc[0] = EXT_CLK_I;
         `GPW_SRC_2: dsrc[0] = PIN_I.lvl[`GPW_PIN10];
         `GPW_SRC_3: dsrc[0] = GP_LOW_I[0];
      endcase
      unique case (divctl_reg[`GPW_DB_SRC])
         `GPW_SRC_0: dsrc[1] = ref_reg[1];
         `GPW_SRC_1: dsrc[1] = EXT_CLK_I;
         `GPW_SRC_2: dsrc[1] = GP_LOW_I[1];
         `GPW_SRC_3: dsrc[1] = dout_reg[0];
      endcase
      dsrc[0] = dsrc[0] ^ divctl_reg[`GPW_DA_INV];
      dsrc[1] = dsrc[1] ^ divctl_reg[`GPW_DB_INV];
      dhold   = {divctl_reg[`GPW_DB_HOLD], divctl_reg[`GPW_DA_HOLD]};
      dprev_next = dsrc;
      for (int i = 0; i < 2; i++) begin
         dedge[i]     = dsrc[i] & ~dprev_reg[i];
         dcnt_next[i] = dcnt_reg[i];
         dout_next[i] = dout_reg[i];
         if (dhold[i]) begin
            dcnt_next[i] = '0;
            dout_next[i] = 1'b0;
         end else if (dedge[i]) begin
            if (dcnt_reg[i] == ratio_reg[i]) begin
               dcnt_next[i] = '0;
               dout_next[i] = ~dout_reg[i];
            end else begin
               dcnt_next[i] = dcnt_reg[i] + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         dprev_reg <= 2'h0;
         dout_reg  <= 2'h0;
         dcnt_reg  <= '{'0, '0};
      end else begin
         dprev_reg <= dprev_next;
         dout_reg  <= dout_next;
         dcnt_reg  <= dcnt_next;
      end
   end

   // ==================================================================
   // pin drivers, flip-flop sources and side port
   logic       p10_prev_reg, p10_prev_next;
   logic       ext_prev_reg, ext_prev_next;
   logic       dff13_reg, dff13_next;
   logic       dff14_reg, dff14_next;
   logic [4:0] pin_o_next, pin_oe_next;
   logic [7:0] aux_o_next, aux_oe_next;
   logic       wake_next;
   logic       p8, p9;

   function automatic logic sel4(input logic [1:0] s, input logic a, input logic b,
                                 input logic c, input logic d);
      unique case (s)
         `GPW_SRC_0: sel4 = a;
         `GPW_SRC_1: sel4 = b;
         `GPW_SRC_2: sel4 = c;
         `GPW_SRC_3: sel4 = d;
      endcase
   endfunction : sel4

   always_comb begin
      p8            = PIN_I.lvl[`GPW_PIN8];
      p9            = PIN_I.lvl[`GPW_PIN9];
      p10_prev_next = PIN_I.lvl[`GPW_PIN10];
      ext_prev_next = EXT_CLK_I;
      dff13_next    = dff13_reg;
      dff14_next    = dff14_reg;
      if (PIN_I.lvl[`GPW_PIN10] && !p10_prev_reg) begin
         dff13_next = p9;
      end
      if (EXT_CLK_I && !ext_prev_reg) begin
         dff14_next = p8;
      end
      pin_o_next[`GPW_PIN8]  = sel4(pctl_reg[0][`GPW_PCTL_SRC], pctl_reg[0][`GPW_PCTL_VAL],
                                    dout_reg[0], dout_reg[1], ~(GP_LOW_I[0] & GP_LOW_I[1]));
      pin_o_next[`GPW_PIN9]  = sel4(pctl_reg[1][`GPW_PCTL_SRC], pctl_reg[1][`GPW_PCTL_VAL],
                                    dout_reg[0], dout_reg[1], ~(GP_LOW_I[2] & GP_LOW_I[3]));
      pin_o_next[`GPW_PIN10] = sel4(pctl_reg[2][`GPW_PCTL_SRC], pctl_reg[2][`GPW_PCTL_VAL],
                                    dout_reg[0], dout_reg[1], EXT_CLK_I);
      pin_o_next[`GPW_PIN13] = sel4(pin1314_reg[`GPW_P13_SRC], pin1314_reg[`GPW_P13_VAL],
                                    dff13_reg, GP_LOW_I[4] & GP_LOW_I[5],
                                    GP_LOW_I[4] | GP_LOW_I[5]);
      pin_o_next[`GPW_PIN14] = sel4(pin1314_reg[`GPW_P14_SRC], pin1314_reg[`GPW_P14_VAL],
                                    dff14_reg, ~(p8 & p9), ~(p8 | p9));
      pin_oe_next = {pin1314_reg[`GPW_P14_DIR], pin1314_reg[`GPW_P13_DIR],
                     pctl_reg[2][`GPW_PCTL_DIR], pctl_reg[1][`GPW_PCTL_DIR],
                     pctl_reg[0][`GPW_PCTL_DIR]};
      aux_o_next  = aux_lvl_reg;
      aux_oe_next = aux_dir_reg;
      if (AUX_ADDR_MODE_I) begin
         aux_o_next[1:0]  = PERIPH_ADDR_HI_I;
         aux_oe_next[1:0] = 2'h3;
      end
      wake_next = |(aux_wake_reg & (AUX_I ^ aux_pol_reg));
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (SRST_I) begin
         p10_prev_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
         dff13_reg    <= 1'b0;
         dff14_reg    <= 1'b0;
         PIN_O        <= 5'h00;
         PIN_OE_O     <= 5'h00;
         AUX_O        <= 8'h00;
         AUX_OE_O     <= 8'h00;
         WAKE_O       <= 1'b0;
      end else begin
         p10_prev_reg <= p10_prev_next;
         ext_prev_reg <= ext_prev_next;
         dff13_reg    <= dff13_next;
         dff14_reg    <= dff14_next;
         PIN_O        <= pin_o_next;
         PIN_OE_O     <= pin_oe_next;
         AUX_O        <= aux_o_next;
         AUX_OE_O     <= aux_oe_next;
         WAKE_O       <= wake_next;
      end
   end

   // ==================================================================
   // assertions
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (SRST_I);

   property p_pin13_and;
      (pin1314_reg[`GPW_P13_SRC] == `GPW_SRC_2) |=>
         PIN_O[`GPW_PIN13] == ($past(GP_LOW_I[4]) & $past(GP_LOW_I[5]));
   endproperty
   a_pin13_and: assert property (p_pin13_and) else $error("pin 13 AND source wrong");

   property p_pin14_nor;
      (pin1314_reg[`GPW_P14_SRC] == `GPW_SRC_3) |=>
         PIN_O[`GPW_PIN14] == ~($past(p8) | $past(p9));
   endproperty
   a_pin14_nor: assert property (p_pin14_nor) else $error("pin 14 NOR source wrong");

   property p_dff13;
      $rose(PIN_I.lvl[`GPW_PIN10]) |=> dff13_reg == $past(PIN_I.lvl[`GPW_PIN9]);
   endproperty
   a_dff13: assert property (p_dff13) else $error("pin 13 flip-flop missed data");

   property p_dff14;
      !(EXT_CLK_I && !ext_prev_reg) |=> $stable(dff14_reg);
   endproperty
   a_dff14: assert property (p_dff14) else $error("pin 14 flip-flop moved off edge");

   property p_aux_read;
      (REG_REQ_I.rd && REG_REQ_I.addr == `GPW_ADDR_AUXLVL) |=> REG_RDATA_O == $past(AUX_I);
   endproperty
   a_aux_read: assert property (p_aux_read) else $error("side port read not live");

   property p_pin_read;
      (REG_REQ_I.rd && REG_REQ_I.addr == `GPW_ADDR_PIN1314) |=>
         REG_RDATA_O[`GPW_P13_VAL] == $past(PIN_I.lvl[`GPW_PIN13]);
   endproperty
   a_pin_read: assert property (p_pin_read) else $error("pin 13 value not live");

   property p_aux_dir;
      !AUX_ADDR_MODE_I ##1 !AUX_ADDR_MODE_I |-> AUX_OE_O == $past(aux_dir_reg);
   endproperty
   a_aux_dir: assert property (p_aux_dir) else $error("side port enable wrong");

   property p_wake_off;
      (aux_wake_reg == 8'h00) [*2] |-> !WAKE_O;
   endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake without enable");

   property p_hold_a;
      divctl_reg[`GPW_DA_HOLD] |=> !dout_reg[0] && dcnt_reg[0] == '0;
   endproperty
   a_hold_a: assert property (p_hold_a) else $error("divider A not held low");

   property p_toggle_a;
      $changed(dout_reg[0]) && !$past(dhold[0]) |->
         $past(dedge[0]) && $past(dcnt_reg[0]) == $past(ratio_reg[0]);
   endproperty
   a_toggle_a: assert property (p_toggle_a) else $error("divider A toggled early");

   property p_pin8_diva;
      (pctl_reg[0][`GPW_PCTL_SRC] == `GPW_SRC_1) |=> PIN_O[`GPW_PIN8] == $past(dout_reg[0]);
   endproperty
   a_pin8_diva: assert property (p_pin8_diva) else $error("pin 8 divider A route");

endmodule : gpw_top
`default_nettype wire

// File: logic/gpw_cfg.svh
`ifndef GPW_CFG_SVH
`define GPW_CFG_SVH

// =====================================================================
// register offsets
`define GPW_ADDR_PIN1314  8'h11
`define GPW_ADDR_AUXLVL   8'h12
`define GPW_ADDR_AUXDIR   8'h13
`define GPW_ADDR_AUXPOL   8'h14
`define GPW_ADDR_AUXWAKE  8'h15
`define GPW_ADDR_DIVA     8'h17
`define GPW_ADDR_DIVB     8'h18
`define GPW_ADDR_DIVCTL   8'h19
`define GPW_ADDR_PIN8     8'h1A
`define GPW_ADDR_PIN9     8'h1B
`define GPW_ADDR_PIN10    8'h1C
`define GPW_RST_VAL       8'h00
`define GPW_READ_ZERO     8'h00

// =====================================================================
// field positions
`define GPW_P13_DIR       0
`define GPW_P13_VAL       1
`define GPW_P14_DIR       2
`define GPW_P14_VAL       3
`define GPW_P13_SRC       5:4
`define GPW_P14_SRC       7:6
`define GPW_PCTL_DIR      0
`define GPW_PCTL_VAL      1
`define GPW_PCTL_SRC      3:2
`define GPW_PCTL_USED     3:0
`define GPW_DA_SRC        1:0
`define GPW_DA_INV        2
`define GPW_DA_HOLD       3
`define GPW_DB_SRC        5:4
`define GPW_DB_INV        6
`define GPW_DB_HOLD       7

// =====================================================================
// pin vector positions
`define GPW_PIN8          0
`define GPW_PIN9          1
`define GPW_PIN10         2
`define GPW_PIN13         3
`define GPW_PIN14         4

// =====================================================================
// source codes
`define GPW_SRC_0         2'h0
`define GPW_SRC_1         2'h1
`define GPW_SRC_2         2'h2
`define GPW_SRC_3         2'h3

// =====================================================================
// clock rates in Hz, accumulator width in bits
`define GPW_SYS_HZ        50000000
`define GPW_FAST_HZ       12000000
`define GPW_SLOW_HZ       93750
`define GPW_ACC_W         27

`endif

// File: logic/gpw_pkg.sv
`default_nettype none
package gpw_pkg;
   // register request from the endpoint side
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } gpw_req_type;

   // pin lines of the five programmable pins
   typedef struct packed {
      logic [4:0] lvl;
   } gpw_pins_type;
endpackage : gpw_pkg
`default_nettype wire

// File: verif/gpw_board.sv
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// board model: resolves shared pin and side lines
module gpw_board (
   // device side
   input  wire logic [4:0]            pin_o_i,
   input  wire logic [4:0]            pin_oe_i,
   input  wire logic [7:0]            aux_o_i,
   input  wire logic [7:0]            aux_oe_i,
   // board drive where the device lets go
   input  wire logic [4:0]            pin_drv_i,
   input  wire logic [7:0]            aux_drv_i,
   // resolved wire levels
   output var  gpw_pkg::gpw_pins_type pin_lvl_o,
   output var  logic [7:0]            aux_lvl_o
);
   always_comb begin
      pin_lvl_o.lvl = (pin_oe_i & pin_o_i) | (~pin_oe_i & pin_drv_i);
      aux_lvl_o     = (aux_oe_i & aux_o_i) | (~aux_oe_i & aux_drv_i);
   end
endmodule : gpw_board

`default_nettype wire

// File: verif/gpw_top_test.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) \
   total_checks++; \
   if ((gt) !== (ex)) begin \
      errors++; \
      $display("wrong value %s expected %h seen %h", nm, ex, gt); \
   end

module gpw_top_test;
   typedef struct {
      logic [7:0] addr;
      logic [7:0] data;
      logic [7:0] rexp;
   } gpw_reg_type;
   typedef struct {
      logic [7:0] addr;
      logic [7:0] data;
      logic [7:0] low;
      logic [4:0] pdrv;
      logic [9:0] mask;
      logic [9:0] exp;
   } gpw_pin_type;

   logic                  clk = 1'b0;
   logic                  srst = 1'b1;
   gpw_pkg::gpw_req_type  req = '0;
   logic [7:0]            gp_low = 8'h00;
   logic                  ext_clk = 1'b0;
   logic                  aux_mode = 1'b0;
   logic [1:0]            addr_hi = 2'b00;
   logic [4:0]            pdrv = 5'h00;
   logic [7:0]            adrv = 8'h00;
   gpw_pkg::gpw_pins_type pin_lvl;
   logic [7:0]            aux_lvl, rdata, aux_o, aux_oe;
   logic [4:0]            pin_o, pin_oe;
   logic                  wake;
   logic                  last0 = 1'b0;
   int                    errors = 0;
   int                    total_checks = 0;
   int                    tog = 0;
   int                    t0;

   gpw_reg_type regs [10] = '{
      '{8'h13, 8'hA5, 8'hA5}, '{8'h14, 8'h5A, 8'h5A}, '{8'h15, 8'hC3, 8'hC3},
      '{8'h17, 8'hFF, 8'hFF}, '{8'h18, 8'h80, 8'h80}, '{8'h19, 8'h3C, 8'h3C},
      '{8'h1A, 8'hF3, 8'h03}, '{8'h1B, 8'hF0, 8'h00}, '{8'h1C, 8'hFC, 8'h0C},
      '{8'h16, 8'hFF, 8'h00}};
   gpw_pin_type pins [16] = '{
      '{8'h1A, 8'h03, 8'h00, 5'h00, 10'h021, 10'h021},
      '{8'h1A, 8'h0D, 8'h03, 5'h00, 10'h001, 10'h000},
      '{8'h1A, 8'h0D, 8'h01, 5'h00, 10'h001, 10'h001},
      '{8'h1B, 8'h0D, 8'h0C, 5'h00, 10'h002, 10'h000},
      '{8'h1B, 8'h0D, 8'h04, 5'h00, 10'h002, 10'h002},
      '{8'h11, 8'h21, 8'h30, 5'h00, 10'h008, 10'h008},
      '{8'h11, 8'h21, 8'h10, 5'h00, 10'h008, 10'h000},
      '{8'h11, 8'h31, 8'h10, 5'h00, 10'h008, 10'h008},
      '{8'h11, 8'h03, 8'h00, 5'h00, 10'h108, 10'h108},
      '{8'h1A, 8'h00, 8'h00, 5'h00, 10'h000, 10'h000},
      '{8'h1B, 8'h00, 8'h00, 5'h00, 10'h000, 10'h000},
      '{8'h11, 8'h84, 8'h00, 5'h03, 10'h010, 10'h000},
      '{8'h11, 8'h84, 8'h00, 5'h01, 10'h010, 10'h010},
      '{8'h11, 8'hC4, 8'h00, 5'h00, 10'h010, 10'h010},
      '{8'h11, 8'hC4, 8'h00, 5'h02, 10'h010, 10'h000},
      '{8'h11, 8'h0C, 8'h00, 5'h00, 10'h210, 10'h210}};

   gpw_top gpw_top_inst (
      .CLK_SYS_I(clk), .SRST_I(srst), .REG_REQ_I(req), .REG_RDATA_O(rdata),
      .GP_LOW_I(gp_low), .PIN_I(pin_lvl), .PIN_O(pin_o), .PIN_OE_O(pin_oe),
      .EXT_CLK_I(ext_clk), .AUX_I(aux_lvl), .AUX_O(aux_o), .AUX_OE_O(aux_oe),
      .AUX_ADDR_MODE_I(aux_mode), .PERIPH_ADDR_HI_I(addr_hi), .WAKE_O(wake));
   gpw_board gpw_board_inst (
      .pin_o_i(pin_o), .pin_oe_i(pin_oe), .aux_o_i(aux_o), .aux_oe_i(aux_oe),
      .pin_drv_i(pdrv), .aux_drv_i(adrv), .pin_lvl_o(pin_lvl), .aux_lvl_o(aux_lvl));

   always #10 clk = ~clk;

   // counts every change on pin 8
   always @(posedge clk) begin
      if (pin_o[0] !== last0) tog++;
      last0 = pin_o[0];
   end

   // =====================================================================
   // bus and helper tasks
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1 req = '{1'b1, 1'b0, a, d};
      @(posedge clk) #1 req = '0;
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex, input string nm);
      @(posedge clk) #1 req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk) #1 req = '0;
      @(posedge clk) #1;
      `CHK(nm, ex, rdata)
   endtask : rd_chk

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task automatic pulses(input int n);
      repeat (n) begin
         gp_low[0] = 1'b1;
         settle(2);
         gp_low[0] = 1'b0;
         settle(2);
      end
   endtask : pulses

   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run

   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      $display("timeout");
      complete_run();
   end

   // =====================================================================
   // main sequence
   initial begin
      settle(4);
      srst = 1'b0;
      foreach (regs[i]) begin
         wr_reg(regs[i].addr, regs[i].data);
         rd_chk(regs[i].addr, regs[i].rexp, "reg");
      end
      $display("test registers done");
      srst = 1'b1;
      settle(2);
      srst = 1'b0;
      for (int a = 8'h11; a <= 8'h1C; a++) rd_chk(8'(a), 8'h00, "reset");
      rd_chk(8'h30, 8'h00, "unmapped");
      `CHK("oe", 13'h0000, {aux_oe, pin_oe})
      $display("test reset done");
      foreach (pins[i]) begin
         wr_reg(pins[i].addr, pins[i].data);
         gp_low = pins[i].low;
         pdrv = pins[i].pdrv;
         settle(3);
         `CHK("pins", pins[i].exp, {pin_oe, pin_o} & pins[i].mask)
      end
      wr_reg(8'h11, 8'h00);
      pdrv = 5'h08;
      rd_chk(8'h11, 8'h02, "live in");
      wr_reg(8'h11, 8'h01);
      rd_chk(8'h11, 8'h01, "live out");
      wr_reg(8'h11, 8'h11);
      pdrv = 5'h02;
      settle(2);
      pdrv = 5'h06;
      settle(3);
      `CHK("ff13", 1'b1, pin_o[3])
      pdrv = 5'h00;
      settle(2);
      pdrv = 5'h04;
      settle(3);
      `CHK("ff13", 1'b0, pin_o[3])
      wr_reg(8'h11, 8'h44);
      pdrv = 5'h01;
      settle(2);
      ext_clk = 1'b1;
      settle(3);
      `CHK("ff14", 1'b1, pin_o[4])
      pdrv = 5'h00;
      wr_reg(8'h1C, 8'h0D);
      settle(3);
      `CHK("pin10", 1'b1, pin_o[2])
      ext_clk = 1'b0;
      settle(3);
      `CHK("pin10 ff14", 2'b01, {pin_o[2], pin_o[4]})
      $display("test pins done");
      wr_reg(8'h13, 8'h0F);
      wr_reg(8'h12, 8'h05);
      adrv = 8'hA0;
      settle(3);
      `CHK("aux drive", 12'h0F5, {aux_oe, aux_o[3:0]})
      rd_chk(8'h12, 8'hA5, "aux read");
      aux_mode = 1'b1;
      addr_hi = 2'b10;
      settle(3);
      `CHK("aux addr", 4'hE, {aux_oe[1:0], aux_o[1:0]})
      rd_chk(8'h12, 8'hA6, "aux addr read");
      aux_mode = 1'b0;
      wr_reg(8'h13, 8'h00);
      adrv = 8'h01;
      wr_reg(8'h15, 8'h01);
      settle(3);
      `CHK("wake", 1'b1, wake)
      wr_reg(8'h14, 8'h01);
      settle(3);
      `CHK("wake inv", 1'b0, wake)
      rd_chk(8'h12, 8'h01, "aux plain");
      wr_reg(8'h14, 8'h00);
      wr_reg(8'h15, 8'h02);
      settle(3);
      `CHK("wake off", 1'b0, wake)
      $display("test aux done");
      wr_reg(8'h17, 8'h01);
      wr_reg(8'h19, 8'h03);
      wr_reg(8'h1A, 8'h05);
      settle(4);
      t0 = tog;
      pulses(8);
      settle(4);
      `CHK("div a", 4, tog - t0)
      wr_reg(8'h19, 8'h0B);
      settle(4);
      t0 = tog;
      pulses(4);
      `CHK("hold", 33'h0_0000_0000, {pin_o[0], tog - t0})
      wr_reg(8'h17, 8'h00);
      wr_reg(8'h19, 8'h07);
      settle(4);
      t0 = tog;
      gp_low[0] = 1'b1;
      settle(4);
      `CHK("inv rise", 0, tog - t0)
      gp_low[0] = 1'b0;
      settle(4);
      `CHK("inv fall", 1, tog - t0)
      wr_reg(8'h17, 8'h01);
      wr_reg(8'h18, 8'h00);
      wr_reg(8'h19, 8'h33);
      wr_reg(8'h1A, 8'h09);
      settle(4);
      t0 = tog;
      pulses(8);
      settle(6);
      `CHK("div b", 2, tog - t0)
      wr_reg(8'h19, 8'h00);
      wr_reg(8'h17, 8'h00);
      wr_reg(8'h1A, 8'h05);
      settle(4);
      t0 = tog;
      settle(500);
      `CHK("fast ref", 1'b1, (tog - t0 >= 118 && tog - t0 <= 122))
      wr_reg(8'h18, 8'h00);
      wr_reg(8'h19, 8'hA0);
      wr_reg(8'h1B, 8'h09);
      settle(4);
      `CHK("hold b", 1'b0, pin_o[1])
      wr_reg(8'h19, 8'h20);
      gp_low[1] = 1'b1;
      settle(4);
      `CHK("div b pin", 1'b1, pin_o[1])
      $display("test dividers done");
      complete_run();
   end
endmodule : gpw_top_test

`default_nettype wire
